// [dv/hbhc_chk_asserts.sv]
// Port checker for the half-bridge and Hall control block
`timescale 1ns/1ps
module hbhc_chk import hbhc_pkg::*; #(
  parameter int N_BRIDGE = 4
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Open-drain lines
  input wire logic                rst_line_in,
  input wire logic                rst_line_out,
  input wire logic                rst_line_oe_n,
  input wire logic                irq_line_out,
  input wire logic                irq_line_oe_n,
  // Gates, gate status and switch
  input wire logic [N_BRIDGE-1:0] bridge_high_side_on,
  input wire logic [N_BRIDGE-1:0] bridge_low_side_on,
  input wire logic [N_BRIDGE-1:0] low_gate_off,
  input wire logic [N_BRIDGE-1:0] high_gate_off,
  input wire logic                high_side_switch_out,
  // Fault comparators
  input wire logic                high_side_overcurrent,
  input wire logic                low_side_overcurrent,
  input wire logic                low_voltage,
  input wire logic                high_voltage
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Any gate on at all
  wire logic [N_BRIDGE-1:0] any_on = bridge_high_side_on | bridge_low_side_on;
  // Fault seen while the shared reset line is released
  wire logic fault = rst_line_in && (high_side_overcurrent ||
    low_side_overcurrent || low_voltage || high_voltage);

  no_shoot_a: assert property (
    (bridge_high_side_on & bridge_low_side_on) == '0)
    else $error("both sides of one bridge on");
  bbm_high_a: assert property (
    (bridge_high_side_on & ~$past(bridge_high_side_on) & ~$past(low_gate_off))
      == '0) else $error("high side on before low gate off");
  bbm_low_a: assert property (
    (bridge_low_side_on & ~$past(bridge_low_side_on) & ~$past(high_gate_off))
      == '0) else $error("low side on before high gate off");
  irq_pend_a: assert property (fault |-> ##[1:2] !irq_line_oe_n)
    else $error("interrupt line not pulled on fault");
  od_data_a: assert property (!rst_line_out && !irq_line_out)
    else $error("open-drain data not low");
  rst_pull_a: assert property ($fell(rst) |-> !rst_line_oe_n [*8])
    else $error("reset line not pulled after reset");
  line_clear_a: assert property (
    !rst_line_in |-> ##2 any_on == '0)
    else $error("gates on while reset line low");
  oc_high_a: assert property (
    rst_line_in && high_side_overcurrent |-> ##2
    bridge_high_side_on == '0) else $error("high sides on after overcurrent");
  oc_low_a: assert property (
    rst_line_in && low_side_overcurrent |-> ##2
    bridge_low_side_on == '0) else $error("low sides on after overcurrent");
  volt_off_a: assert property (
    rst_line_in && (low_voltage || high_voltage)
    |-> ##2 any_on == '0) else $error("gates on with voltage fault");

  // Main scenarios reached
  cover property (|bridge_high_side_on);
  cover property ($fell(irq_line_oe_n));
  cover property ($rose(high_side_switch_out));
endmodule : hbhc_chk

// [dv/hbhc_host.sv]
// Host model: SPI master, open-drain line resolution, period reference
`timescale 1ns/1ps
module hbhc_host import hbhc_pkg::*; #(
  parameter int REF_PER = 64,
  parameter int REF_HI  = 8
) (
  // Clock
  input  wire logic clk,
  // SPI master pins
  output logic      ss_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  // Open-drain lines from the device
  input  wire logic rst_line_out,
  input  wire logic rst_line_oe_n,
  input  wire logic irq_line_out,
  input  wire logic irq_line_oe_n,
  // Resolved lines and period reference
  output logic      rst_line,
  output logic      irq_n,
  output logic      pwm_period_ref
);
  logic host_pull = 1'b0;

  // Pull-ups hold both lines high unless someone pulls them low
  assign rst_line = ~host_pull & (rst_line_oe_n | rst_line_out);
  assign irq_n = irq_line_oe_n | irq_line_out;

  // Short high pulse, so a pass-through of the pulse width would show
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    pwm_period_ref = 1'b0;
    forever begin
      repeat (REF_PER - REF_HI) @(posedge clk);
      pwm_period_ref <= 1'b1;
      repeat (REF_HI) @(posedge clk);
      pwm_period_ref <= 1'b0;
    end
  end

  // Header then data byte, MSB first; select from a general output
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat,
                      output logic [7:0] got);
    logic [15:0] sh;
    sh = {hdr, dat};
    got = 8'h00;
    @(posedge clk);
    ss_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      mosi <= sh[i];
      repeat (2) @(posedge clk);
      @(negedge clk);
      if (i < 8) got[i] = miso;
      @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : xfer

  // Host drives the shared reset line low for n cycles
  task automatic pull(input int n);
    @(posedge clk);
    host_pull <= 1'b1;
    repeat (n) @(posedge clk);
    host_pull <= 1'b0;
  endtask : pull
endmodule : hbhc_host

// [dv/testbench.sv]
// Self-checking bench for the half-bridge and Hall control block
`timescale 1ns/1ps
module testbench import hbhc_pkg::*;;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ss_n, sck, mosi, miso, rst_line, irq_n, pref, hs_out;
  logic       rl_out, rl_oe_n, il_out, il_oe_n;
  logic [3:0] hi, lo, hgo, lgo;
  logic [3:0] stick = 4'h0;
  logic       oc_h = 1'b0;
  logic       oc_l = 1'b0;
  logic       lv = 1'b0;
  logic       hv = 1'b0;
  logic [2:0] hall = 3'h0;
  logic [2:0] hpow;
  int         mismatches = 0;
  int         checked = 0;

  // Ideal gates; stick fakes a low gate slow to report off
  assign hgo = ~hi;
  assign lgo = ~lo & ~stick;

  initial forever #25 clk = ~clk;

  hbhc_top #(.CNT_W(10)) dut (
    .clk(clk), .rst(rst), .rst_line_in(rst_line), .rst_line_out(rl_out),
    .rst_line_oe_n(rl_oe_n), .irq_line_out(il_out), .irq_line_oe_n(il_oe_n),
    .ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso),
    .pwm_period_ref(pref), .bridge_high_side_on(hi),
    .bridge_low_side_on(lo), .high_gate_off(hgo), .low_gate_off(lgo),
    .high_side_switch_out(hs_out), .high_side_overcurrent(oc_h),
    .low_side_overcurrent(oc_l), .low_voltage(lv), .high_voltage(hv),
    .hall_inputs(hall), .hall_input_power(hpow));

  hbhc_host host (
    .clk(clk), .ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso),
    .rst_line_out(rl_out), .rst_line_oe_n(rl_oe_n), .irq_line_out(il_out),
    .irq_line_oe_n(il_oe_n), .rst_line(rst_line), .irq_n(irq_n),
    .pwm_period_ref(pref));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({2'b10, a}, d, r);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({2'b00, a}, 8'h00, r);
    chk8(r, e);
  endtask : rd_chk

  // Gates compared as {high, low} once settled, between edges
  task automatic gates(input logic [7:0] e);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk8({hi, lo}, e);
    @(posedge clk);
  endtask : gates

  // High cycles of the switch over one reference period
  task automatic hs_count(output int n);
    n = 0;
    repeat (64) begin
      @(negedge clk);
      if (hs_out === 1'b1) n++;
    end
    @(posedge clk);
  endtask : hs_count

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Run takes about 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial begin
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 200 && rst_line !== 1'b1; i++) @(posedge clk);
    rd_chk(OFS_BRIDGE_OUTPUT_CMD, 8'h00);
    rd_chk(OFS_HALL_INPUT_CONTROL, 8'h00);
    rd_chk(OFS_HALL_INPUT_STATUS, 8'h00);
    rd_chk(6'h3f, 8'h00);
    // Hall enables, masking and the synchronised status
    wr(OFS_HALL_INPUT_CONTROL, 8'hff);
    rd_chk(OFS_HALL_INPUT_CONTROL, 8'h07);
    chk8({5'h00, hpow}, 8'h07);
    hall <= 3'h5;
    rd_chk(OFS_HALL_INPUT_STATUS, 8'h05);
    wr(OFS_HALL_INPUT_CONTROL, 8'h02);
    rd_chk(OFS_HALL_INPUT_STATUS, 8'h00);
    hall <= 3'h2;
    rd_chk(OFS_HALL_INPUT_STATUS, 8'h02);
    // Bridge commands, stage enable, priority, break-before-make
    wr(OFS_BRIDGE_OUTPUT_CMD, 8'h55);
    gates(8'h00);
    wr(OFS_SYSTEM_CONTROL_REG, 8'h01);
    gates(8'h0f);
    rd_chk(OFS_BRIDGE_OUTPUT_CMD, 8'h55);
    wr(OFS_BRIDGE_OUTPUT_CMD, 8'hff);
    gates(8'hf0);
    wr(OFS_BRIDGE_OUTPUT_CMD, 8'h80);
    gates(8'h80);
    wr(OFS_BRIDGE_OUTPUT_CMD, 8'h01);
    gates(8'h01);
    stick <= 4'h1;
    wr(OFS_BRIDGE_OUTPUT_CMD, 8'h02);
    gates(8'h00);
    stick <= 4'h0;
    gates(8'h10);
    // Soft start of the high-side switch
    wr(OFS_SYSTEM_CONTROL_REG, 8'h03);
    repeat (64) @(posedge clk);
    hs_count(n);
    chk8(8'(n > 0 && n < 32), 8'h01);
    repeat (20 * 64) @(posedge clk);
    hs_count(n);
    chk8(8'(n), 8'h40);
    // Over-current on both sides, then clear
    oc_h <= 1'b1;
    oc_l <= 1'b1;
    @(posedge clk);
    oc_h <= 1'b0;
    oc_l <= 1'b0;
    gates(8'h00);
    chk8({7'h00, irq_n}, 8'h00);
    rd_chk(OFS_SYSTEM_STATUS_REG, 8'h01);
    wr(OFS_SYSTEM_STATUS_REG, 8'h01);
    gates(8'h10);
    chk8({7'h00, irq_n}, 8'h01);
    // Voltage flags re-set while the condition holds
    lv <= 1'b1;
    gates(8'h00);
    wr(OFS_INTERRUPT_FLAG_REG, 8'h01);
    lv <= 1'b0;
    hv <= 1'b1;
    rd_chk(OFS_INTERRUPT_FLAG_REG, 8'h03);
    hv <= 1'b0;
    wr(OFS_INTERRUPT_FLAG_REG, 8'h03);
    rd_chk(OFS_INTERRUPT_FLAG_REG, 8'h00);
    gates(8'h10);
    // Host pulls the shared reset line
    host.pull(4);
    gates(8'h00);
    rd_chk(OFS_BRIDGE_OUTPUT_CMD, 8'h00);
    finish_test();
  end
endmodule : testbench

bind hbhc_top hbhc_chk #(.N_BRIDGE(N_BRIDGE)) chk (
  .clk(clk), .rst(rst), .rst_line_in(rst_line_in),
  .rst_line_out(rst_line_out), .rst_line_oe_n(rst_line_oe_n),
  .irq_line_out(irq_line_out), .irq_line_oe_n(irq_line_oe_n),
  .bridge_high_side_on(bridge_high_side_on),
  .bridge_low_side_on(bridge_low_side_on), .low_gate_off(low_gate_off),
  .high_gate_off(high_gate_off), .high_side_switch_out(high_side_switch_out),
  .high_side_overcurrent(high_side_overcurrent),
  .low_side_overcurrent(low_side_overcurrent),
  .low_voltage(low_voltage), .high_voltage(high_voltage));

// [verilog/hbhc_pkg.sv]
// Shared constants and types of the half-bridge and Hall control block
package hbhc_pkg;

  // Register offsets on the SPI port
  localparam logic [5:0] OFS_BRIDGE_OUTPUT_CMD  = 6'h01;
  localparam logic [5:0] OFS_HALL_INPUT_CONTROL = 6'h08;
  localparam logic [5:0] OFS_HALL_INPUT_STATUS  = 6'h09;
  localparam logic [5:0] OFS_SYSTEM_CONTROL_REG = 6'h0c;
  localparam logic [5:0] OFS_SYSTEM_STATUS_REG  = 6'h0d;
  localparam logic [5:0] OFS_INTERRUPT_FLAG_REG = 6'h0e;

  // Reset values
  localparam logic [7:0] RST_BRIDGE_OUTPUT_CMD  = 8'h00;
  localparam logic [2:0] RST_HALL_INPUT_CONTROL = 3'h0;
  localparam logic [2:0] RST_HALL_INPUT_STATUS  = 3'h0;
  localparam logic [1:0] RST_SYSTEM_CONTROL     = 2'h0;

  // Field positions
  localparam int POS_POWER_STAGE_ENABLE   = 0;
  localparam int POS_HIGH_SIDE_SWITCH     = 1;
  localparam int POS_BRIDGE_OVERCURRENT   = 0;
  localparam int POS_LOW_VOLTAGE_FLAG     = 0;
  localparam int POS_HIGH_VOLTAGE_FLAG    = 1;
  localparam int POS_SPI_WRITE            = 7;

  // Timing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int RST_PULL_NS      = 1000;
  localparam int RST_PULL_CYC     =
    (RST_PULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_START = 8'h10;
  localparam logic [7:0] RAMP_STEP  = 8'h10;
  localparam logic [7:0] DUTY_FULL  = 8'hff;

  // SPI slave states, Gray from idle to data; data back to address flips both bits
  typedef enum logic [1:0] {
    HBHC_SPI_IDLE = 2'b00,
    HBHC_SPI_ADDR = 2'b01,
    HBHC_SPI_LOAD = 2'b11,
    HBHC_SPI_DATA = 2'b10
  } hbhc_spi_st_t;

  // One register write from the SPI port
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } hbhc_wr_t;

endpackage : hbhc_pkg

// [verilog/hbhc_pwm.sv]
// PWM generator timed by the period reference, duty supplied locally
`timescale 1ns/1ps
module hbhc_pwm import hbhc_pkg::*; #(
  parameter int CNT_W = 18
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Period reference and duty
  input  wire logic       period_ref,
  input  wire logic [7:0] duty,
  // Output
  output logic            pwm_q,
  output logic            period_tick
);

  logic             ref_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] thr_q;

  // Only the rising edge matters; the input pulse width is ignored
  wire ref_rise = period_ref & ~ref_q;
  wire cnt_max  = &cnt_q;
  wire [CNT_W+7:0] prod = cnt_q * duty;

  assign period_tick = ref_rise;

  // Measure the period, derive the on time for the next one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_q <= 1'b0;
      cnt_q <= '0;
      thr_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      ref_q <= period_ref;
      if (ref_rise) begin
        cnt_q <= '0;
        thr_q <= prod[CNT_W+7:8];
      end else if (!cnt_max) begin
        cnt_q <= cnt_q + 1'b1;
      end
      pwm_q <= (duty == DUTY_FULL) | (cnt_q < thr_q);
    end
  end

endmodule : hbhc_pwm

// [verilog/hbhc_spi_slave.sv]
// SPI register port: header byte then data byte, mode 0, MSB first
`timescale 1ns/1ps
module hbhc_spi_slave import hbhc_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // SPI pins
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Register access
  output logic [5:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output hbhc_wr_t        wr,
  output logic            wr_vld
);

  hbhc_spi_st_t st_q;
  logic         sck_q;
  logic [2:0]   cnt_q;
  logic [7:0]   sh_q;
  logic [7:0]   hdr_q;
  logic [7:0]   out_q;
  logic         vld_q;

  // Edge detect; sck must stay two clocks per half period
  wire sck_rise = sck & ~sck_q;
  wire sck_fall = ~sck & sck_q;
  wire last_bit = sck_rise & (cnt_q == 3'h7);
  wire [7:0] sh_next = {sh_q[6:0], mosi};

  assign rd_addr = hdr_q[5:0];
  assign miso    = out_q[7];
  assign wr      = '{addr: hdr_q[5:0], data: sh_q}; // Byte already in
  assign wr_vld  = vld_q;

  // Frame sequencer; raising ss_n aborts the frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= HBHC_SPI_IDLE;
      sck_q <= 1'b0;
      cnt_q <= 3'h0;
      sh_q  <= 8'h00;
      hdr_q <= 8'h00;
      out_q <= 8'h00;
      vld_q <= 1'b0;
    end else begin
      sck_q <= sck;
      vld_q <= 1'b0;
      if (sck_rise) begin
        sh_q  <= sh_next;
        cnt_q <= cnt_q + 3'h1;
      end
      if (ss_n) begin
        st_q  <= HBHC_SPI_IDLE;
        cnt_q <= 3'h0;
      end else begin
        case (st_q)
          HBHC_SPI_IDLE: begin
            st_q  <= HBHC_SPI_ADDR;
            cnt_q <= 3'h0;
          end
          HBHC_SPI_ADDR: begin
            if (last_bit) begin
              hdr_q <= sh_next;
              st_q  <= HBHC_SPI_LOAD;
            end
          end
          HBHC_SPI_LOAD: begin
            out_q <= rd_data;
            st_q  <= HBHC_SPI_DATA;
          end
          HBHC_SPI_DATA: begin
            // No shift on the fall that ends the header byte
            if (sck_fall && cnt_q != 3'h0) begin
              out_q <= {out_q[6:0], 1'b0};
            end
            if (last_bit) begin
              vld_q <= hdr_q[POS_SPI_WRITE];
              st_q  <= HBHC_SPI_ADDR;
            end
          end
          default: st_q <= HBHC_SPI_IDLE;
        endcase
      end
    end
  end

endmodule : hbhc_spi_slave

// [verilog/hbhc_top.sv]
// Half-bridge, high-side switch and Hall input control with SPI registers
//
// Contract
// - Hall control at 0x08: bits 2:0 enable inputs, reset zero, rest zero.
// - Hall status at 0x09 reads inputs only while enabled; reset clears.
// - Bridge command at 0x01: bit 2n low side, 2n+1 high side.
// - Reset clears the bridge command, switching every transistor off.
// - Low-side bits switch that transistor, read back, clear on reset.
// - Each transistor commanded alone; no bridge drives without stage enable.
// - Both bits set drives high side and holds low side off.
// - Each side turns on only after the other gate reports off.
// - Open-drain active-low interrupt while an error flag is pending.
// - Open-drain reset line; device pulls it, external low resets.
// - Period reference sets PWM period only; duty made internally.
// - High-side switch soft-starts with PWM timed by the reference.
// - Over-current kills that side on all bridges, sets W1C flag.
// - Voltage flags disable bridges; W1C, re-set while condition holds.
`timescale 1ns/1ps
module hbhc_top import hbhc_pkg::*; #(
  parameter int N_BRIDGE = 4,
  parameter int N_HALL   = 3,
  parameter int CNT_W    = 18
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Shared open-drain reset line
  input  wire logic                rst_line_in,
  output logic                     rst_line_out,
  output logic                     rst_line_oe_n,
  // Open-drain interrupt line
  output logic                     irq_line_out,
  output logic                     irq_line_oe_n,
  // SPI register port
  input  wire logic                ss_n,
  input  wire logic                sck,
  input  wire logic                mosi,
  output logic                     miso,
  // Period reference
  input  wire logic                pwm_period_ref,
  // Half-bridge gates and gate-off status
  output logic [N_BRIDGE-1:0]      bridge_high_side_on,
  output logic [N_BRIDGE-1:0]      bridge_low_side_on,
  input  wire logic [N_BRIDGE-1:0] high_gate_off,
  input  wire logic [N_BRIDGE-1:0] low_gate_off,
  // High-side switch
  output logic                     high_side_switch_out,
  // Protection comparators
  input  wire logic                high_side_overcurrent,
  input  wire logic                low_side_overcurrent,
  input  wire logic                low_voltage,
  input  wire logic                high_voltage,
  // Hall sensor inputs and supply switches
  input  wire logic [N_HALL-1:0]   hall_inputs,
  output logic [N_HALL-1:0]        hall_input_power
);

  // Reset line pull counter
  logic [7:0] pull_cnt_q;

  // Registers
  logic [2*N_BRIDGE-1:0] bridge_output_cmd_q;
  logic [N_HALL-1:0]     hall_input_control_q;
  logic [N_HALL-1:0]     hall_input_status_q;
  logic [1:0]            system_control_q;
  logic                  overcurrent_flag_q;
  logic                  high_kill_q;
  logic                  low_kill_q;
  logic                  low_voltage_flag_q;
  logic                  high_voltage_flag_q;

  // Hall synchroniser stages
  logic [N_HALL-1:0]     hall_meta_q;
  logic [N_HALL-1:0]     hall_sync_q;

  // High-side soft start
  logic                  hs_cmd_q;
  logic [7:0]            ramp_q;

  // Gate drive state
  logic [N_BRIDGE-1:0]   high_on_q;
  logic [N_BRIDGE-1:0]   low_on_q;

  // Register port and PWM wires
  logic [5:0]            rd_addr;
  logic [7:0]            rd_data;
  hbhc_wr_t              wr;
  logic                  wr_vld;
  logic                  hs_pwm;
  logic                  period_tick;

  // Offset match shared by all write decodes
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  hbhc_spi_slave u_spi (
    .clk     (clk),
    .rst     (rst),
    .ss_n    (ss_n),
    .sck     (sck),
    .mosi    (mosi),
    .miso    (miso),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .wr      (wr),
    .wr_vld  (wr_vld)
  );

  hbhc_pwm #(
    .CNT_W (CNT_W)
  ) u_pwm (
    .clk         (clk),
    .rst         (rst),
    .period_ref  (pwm_period_ref),
    .duty        (ramp_q),
    .pwm_q       (hs_pwm),
    .period_tick (period_tick)
  );

  // External low on the shared line acts as a synchronous clear
  wire line_reset = ~rst_line_in;
  wire pulling    = (pull_cnt_q != 8'h00);

  // Device holds the line low during and just after its own reset
  assign rst_line_out  = 1'b0;
  assign rst_line_oe_n = ~pulling;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pull_cnt_q <= 8'(RST_PULL_CYC);
    end else if (pulling) begin
      pull_cnt_q <= pull_cnt_q - 8'h01;
    end
  end

  // Write strobes per register
  wire wr_bridge = wr_vld & hit(wr.addr, OFS_BRIDGE_OUTPUT_CMD);
  wire wr_hctl   = wr_vld & hit(wr.addr, OFS_HALL_INPUT_CONTROL);
  wire wr_sctl   = wr_vld & hit(wr.addr, OFS_SYSTEM_CONTROL_REG);
  wire wr_sstat  = wr_vld & hit(wr.addr, OFS_SYSTEM_STATUS_REG);
  wire wr_iflag  = wr_vld & hit(wr.addr, OFS_INTERRUPT_FLAG_REG);

  // Write-one-to-clear requests
  wire clr_oc = wr_sstat & wr.data[POS_BRIDGE_OVERCURRENT];
  wire clr_lv = wr_iflag & wr.data[POS_LOW_VOLTAGE_FLAG];
  wire clr_hv = wr_iflag & wr.data[POS_HIGH_VOLTAGE_FLAG];

  // Control registers, cleared by either reset source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge_output_cmd_q  <= RST_BRIDGE_OUTPUT_CMD;
      hall_input_control_q <= RST_HALL_INPUT_CONTROL;
      system_control_q     <= RST_SYSTEM_CONTROL;
    end else if (line_reset) begin
      bridge_output_cmd_q  <= RST_BRIDGE_OUTPUT_CMD;
      hall_input_control_q <= RST_HALL_INPUT_CONTROL;
      system_control_q     <= RST_SYSTEM_CONTROL;
    end else begin
      if (wr_bridge) begin
        bridge_output_cmd_q <= wr.data;
      end
      if (wr_hctl) begin
        hall_input_control_q <= wr.data[N_HALL-1:0];
      end
      if (wr_sctl) begin
        system_control_q <= wr.data[1:0];
      end
    end
  end

  // Error flags: a fresh event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overcurrent_flag_q  <= 1'b0;
      high_kill_q         <= 1'b0;
      low_kill_q          <= 1'b0;
      low_voltage_flag_q  <= 1'b0;
      high_voltage_flag_q <= 1'b0;
    end else if (line_reset) begin
      overcurrent_flag_q  <= 1'b0;
      high_kill_q         <= 1'b0;
      low_kill_q          <= 1'b0;
      low_voltage_flag_q  <= 1'b0;
      high_voltage_flag_q <= 1'b0;
    end else begin
      overcurrent_flag_q <= high_side_overcurrent | low_side_overcurrent
                          | (overcurrent_flag_q & ~clr_oc);
      high_kill_q <= high_side_overcurrent
                   | (high_kill_q & ~clr_oc);
      low_kill_q  <= low_side_overcurrent
                   | (low_kill_q & ~clr_oc);
      low_voltage_flag_q  <= low_voltage
                           | (low_voltage_flag_q & ~clr_lv);
      high_voltage_flag_q <= high_voltage
                           | (high_voltage_flag_q & ~clr_hv);
    end
  end

  // Hall inputs: first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hall_meta_q <= '0;
      hall_sync_q <= '0;
    end else begin
      hall_meta_q <= hall_inputs;
      hall_sync_q <= hall_meta_q;
    end
  end

  // Status follows an input only while it is powered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hall_input_status_q <= RST_HALL_INPUT_STATUS;
    end else if (line_reset) begin
      hall_input_status_q <= RST_HALL_INPUT_STATUS;
    end else begin
      hall_input_status_q <= hall_sync_q & hall_input_control_q;
    end
  end

  assign hall_input_power = hall_input_control_q;

  // Bridges may conduct only with stage enable and no voltage fault
  wire stage_allow = system_control_q[POS_POWER_STAGE_ENABLE]
                   & ~low_voltage_flag_q & ~high_voltage_flag_q
                   & ~line_reset;

  // Per-bridge gate logic with priority and break-before-make
  genvar gi;
  generate
    for (gi = 0; gi < N_BRIDGE; gi++) begin : g_bridge
      wire cmd_lo = bridge_output_cmd_q[2*gi];
      wire cmd_hi = bridge_output_cmd_q[2*gi+1];
      wire want_hi = cmd_hi & stage_allow & ~high_kill_q;
      // High side wins when both are requested
      wire want_lo = cmd_lo & ~cmd_hi & stage_allow
                   & ~low_kill_q;
      wire start_hi = low_gate_off[gi] & ~low_on_q[gi];
      wire start_lo = high_gate_off[gi] & ~high_on_q[gi];

      // A side once on stays on until its request drops
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          high_on_q[gi] <= 1'b0;
          low_on_q[gi]  <= 1'b0;
        end else begin
          high_on_q[gi] <= want_hi & (high_on_q[gi] | start_hi);
          low_on_q[gi]  <= want_lo
                         & (low_on_q[gi] | start_lo);
        end
      end
    end
  endgenerate

  assign bridge_high_side_on = high_on_q;
  assign bridge_low_side_on  = low_on_q;

  // High-side switch command
  wire hs_cmd = system_control_q[POS_HIGH_SIDE_SWITCH] & ~line_reset;
  wire ramp_full = (ramp_q == DUTY_FULL);
  wire [8:0] ramp_sum = {1'b0, ramp_q} + {1'b0, RAMP_STEP};

  // Soft start: duty climbs one step per reference period to full on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_cmd_q <= 1'b0;
      ramp_q   <= 8'h00;
    end else begin
      hs_cmd_q <= hs_cmd;
      if (!hs_cmd) begin
        ramp_q <= 8'h00;
      end else if (!hs_cmd_q) begin
        ramp_q <= RAMP_START;
      end else if (period_tick && !ramp_full) begin
        ramp_q <= ramp_sum[8] ? DUTY_FULL : ramp_sum[7:0];
      end
    end
  end

  // Without a period reference the switch never reaches full on
  assign high_side_switch_out = hs_cmd_q & hs_pwm;

  // Interrupt line pulled low while any error flag is pending
  wire irq_pending = overcurrent_flag_q | low_voltage_flag_q
                   | high_voltage_flag_q;
  assign irq_line_out  = 1'b0;
  assign irq_line_oe_n = ~irq_pending;

  // Read selection; unmapped offsets and reserved bits read zero
  wire [7:0] rd_bridge = bridge_output_cmd_q;
  wire [7:0] rd_hctl   = {5'h00, hall_input_control_q};
  wire [7:0] rd_hstat  = {5'h00, hall_input_status_q};
  wire [7:0] rd_sctl   = {6'h00, system_control_q};
  wire [7:0] rd_sstat  = {7'h00, overcurrent_flag_q};
  wire [7:0] rd_iflag  = {6'h00, high_voltage_flag_q, low_voltage_flag_q};

  assign rd_data =
    hit(rd_addr, OFS_BRIDGE_OUTPUT_CMD)  ? rd_bridge :
    hit(rd_addr, OFS_HALL_INPUT_CONTROL) ? rd_hctl   :
    hit(rd_addr, OFS_HALL_INPUT_STATUS)  ? rd_hstat  :
    hit(rd_addr, OFS_SYSTEM_CONTROL_REG) ? rd_sctl   :
    hit(rd_addr, OFS_SYSTEM_STATUS_REG)  ? rd_sstat  :
    hit(rd_addr, OFS_INTERRUPT_FLAG_REG) ? rd_iflag  :
    8'h00;

endmodule : hbhc_top
